// [vmc_pkg.sv]
// Constants and carrier types shared by the carrier slave files
package vmc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int CONFIG_MS = 145;
    localparam int CONFIG_CYC = CONFIG_MS * CLK_MHZ * 1000;
    localparam int XFER_NS = 450;
    localparam int XFER_CYC = XFER_NS * CLK_MHZ / 1000;
    localparam int IP_MHZ = 8;
    localparam int IP_WAIT_NS = 125;
    localparam int IP_ACC_STEP = IP_MHZ;
    localparam int IP_ACC_MOD = CLK_MHZ * IP_WAIT_NS * IP_MHZ / 1000;
    localparam int CNT_W = 7;
    localparam int CFG_W = 25;
    localparam int SLOTS = 4;
    localparam logic [7:0] OFF_STATUS = 8'hC1;
    localparam logic [7:0] OFF_MEM_EN = 8'hC7;
    localparam logic [7:0] OFF_BASE0 = 8'hD1;
    localparam logic [1:0] RGN_ID = 2'h2;
    localparam logic [1:0] RGN_UPPER = 2'h3;
    localparam int ST_READY_BIT = 0;
    localparam int BS_SIZE_LSB = 0;
    localparam int BS_BASE_LSB = 2;
    localparam int A24_MIN_BIT = 18;
    localparam logic [3:0] MEM_EN_RST = 4'h0;
    localparam logic [7:0] BASE_RST = 8'h00;
    localparam logic [5:0] AM_A16_USR = 6'h29;
    localparam logic [5:0] AM_A16_SUP = 6'h2D;
    localparam logic [5:0] AM_A24_UD = 6'h39;
    localparam logic [5:0] AM_A24_UP = 6'h3A;
    localparam logic [5:0] AM_A24_SD = 6'h3D;
    localparam logic [5:0] AM_A24_SP = 6'h3E;

    typedef enum logic [2:0] {K_NONE, K_CAR, K_IO, K_ID, K_MEM} vmc_kind_t;
    typedef enum logic [2:0] {S_IDLE, S_IP_SEL, S_IP_WAIT, S_HOLD, S_DONE} vmc_state_t;

    typedef struct packed {
        logic as_n;
        logic [1:0] ds_n;
        logic write_n;
        logic [5:0] am;
        logic [23:1] addr;
        logic [15:0] data;
    } vmc_vme_t;

    typedef struct packed {
        logic [3:0] iosel_n;
        logic [3:0] idsel_n;
        logic [3:0] memsel_n;
        logic [22:1] addr;
        logic rw_n;
        logic [1:0] bs_n;
    } vmc_ip_t;
endpackage

// [vmc_ip_tick.sv]
// Module-side 8 MHz enable from a phase accumulator
`timescale 1ns/100ps
module vmc_ip_tick (
    input wire logic clock,
    input wire logic sys_rst,
    output logic tick
);
    logic [7:0] acc_r, acc_nxt;
    logic tick_r, tick_nxt;

    always_comb begin
        acc_nxt = acc_r + 8'(vmc_pkg::IP_ACC_STEP);
        tick_nxt = 1'b0;
        if (acc_nxt >= 8'(vmc_pkg::IP_ACC_MOD)) begin
            acc_nxt = acc_nxt - 8'(vmc_pkg::IP_ACC_MOD);
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule

// [vmc_carrier_slave.sv]
// Carrier slave: A16 window, A24 module memory, module-side cycles
// How it works
// - No transfer is acknowledged until the configuration delay after reset has elapsed.
// - All module control registers return to defaults whenever reset is applied.
// - Carrier register accesses are acknowledged a fixed 56 clocks (448 ns) after the cycle is taken.
// - Each module wait state adds one 125 ns module clock period to the module cycle, stretching the access once that cycle outlasts the base time.
// - Short accesses are decoded in a 1 KB window selected on a 1 KB boundary.
// - A status register is provided and the carrier carries no identification data.
// - The window holds I/O and ID blocks per slot plus carrier registers, rest unused.
// - A24 space answers for a slot only while that slot's memory enable is set.
// - Each enabled slot's A24 window comes from its own base and size register.
// - ID data sits on odd bytes only; the even lane of an ID read is zero.
`timescale 1ns/100ps
module vmc_carrier_slave #(
    parameter int CONFIG_CYC = vmc_pkg::CONFIG_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [5:0] board_base,
    input vmc_pkg::vmc_vme_t vme,
    output logic [15:0] vme_data_out,
    output logic vme_data_oe,
    output logic vme_dtack_n,
    output logic vme_dtack_oe,
    output vmc_pkg::vmc_ip_t ip_bus,
    input wire logic [15:0] ip_data_in,
    output logic [15:0] ip_data_out,
    output logic ip_data_oe,
    input wire logic [3:0] ip_ack_n
);
    logic ip_tick;
    vmc_pkg::vmc_state_t state_r, state_nxt;
    vmc_pkg::vmc_kind_t kind_r, kind_nxt;
    logic [1:0] slot_r, slot_nxt;
    logic [vmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [vmc_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
    logic ready_r, ready_nxt;
    logic [3:0] mem_en_r, mem_en_nxt;
    logic [3:0][7:0] base_r, base_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic dtack_n_r, dtack_n_nxt;
    vmc_pkg::vmc_ip_t ip_r, ip_nxt;
    logic [15:0] ipdo_r, ipdo_nxt;
    logic ipoe_r, ipoe_nxt;
    logic strobe;
    logic a16_hit;
    logic a24_hit;
    logic [1:0] a24_slot;
    logic dtack_oe_r, dtack_oe_nxt;
    localparam int CFG_W = vmc_pkg::CFG_W;
    localparam vmc_pkg::vmc_state_t S_IDLE = vmc_pkg::S_IDLE;
    localparam vmc_pkg::vmc_state_t S_IP_SEL = vmc_pkg::S_IP_SEL;
    localparam vmc_pkg::vmc_state_t S_IP_WAIT = vmc_pkg::S_IP_WAIT;
    localparam vmc_pkg::vmc_state_t S_HOLD = vmc_pkg::S_HOLD;
    localparam vmc_pkg::vmc_state_t S_DONE = vmc_pkg::S_DONE;
    localparam vmc_pkg::vmc_kind_t K_NONE = vmc_pkg::K_NONE;
    localparam vmc_pkg::vmc_kind_t K_CAR = vmc_pkg::K_CAR;
    localparam vmc_pkg::vmc_kind_t K_IO = vmc_pkg::K_IO;
    localparam vmc_pkg::vmc_kind_t K_ID = vmc_pkg::K_ID;
    localparam vmc_pkg::vmc_kind_t K_MEM = vmc_pkg::K_MEM;

    vmc_ip_tick u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(ip_tick)
    );

    function automatic logic is_a16(input logic [5:0] am);
        return am == vmc_pkg::AM_A16_USR || am == vmc_pkg::AM_A16_SUP;
    endfunction

    function automatic logic is_a24(input logic [5:0] am);
        return am == vmc_pkg::AM_A24_UD || am == vmc_pkg::AM_A24_UP
            || am == vmc_pkg::AM_A24_SD || am == vmc_pkg::AM_A24_SP;
    endfunction

    // Window of 256 KB shifted left by the size code
    function automatic logic win_hit(input logic [23:1] a, input logic [7:0] cfg);
        logic [23:0] mask;
        logic [23:0] base;
        mask = 24'hFFFFFF << (vmc_pkg::A24_MIN_BIT + int'(cfg[vmc_pkg::BS_SIZE_LSB +: 2]));
        base = {cfg[vmc_pkg::BS_BASE_LSB +: 6], 18'h00000};
        return (({a, 1'b0} ^ base) & mask) == 24'h000000;
    endfunction

    function automatic logic [7:0] reg_rd(input logic [7:1] off, input logic rdy,
                                          input logic [3:0] men, input logic [3:0][7:0] b);
        logic [7:0] v;
        v = 8'h00;
        if (off == vmc_pkg::OFF_STATUS[7:1]) begin
            v[vmc_pkg::ST_READY_BIT] = rdy;
        end else if (off == vmc_pkg::OFF_MEM_EN[7:1]) begin
            v = {4'h0, men};
        end else if (off[7:3] == vmc_pkg::OFF_BASE0[7:3]) begin
            v = b[off[2:1]];
        end
        return v;
    endfunction

    assign strobe = ~&vme.ds_n;

    assign a16_hit = is_a16(vme.am) && vme.addr[15:10] == board_base;

    always_comb begin
        a24_hit = 1'b0;
        a24_slot = 2'h0;
        for (int i = vmc_pkg::SLOTS - 1; i >= 0; i--) begin
            if (mem_en_r[i] && is_a24(vme.am) && win_hit(vme.addr, base_r[i])) begin
                a24_hit = 1'b1;
                a24_slot = 2'(i);
            end
        end
    end

    always_comb begin
        cfg_nxt = cfg_r;
        ready_nxt = ready_r;
        if (!ready_r) begin
            cfg_nxt = cfg_r + 1'b1;
            ready_nxt = (cfg_r == CFG_W'(CONFIG_CYC - 1));
        end
    end

    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        slot_nxt = slot_r;
        cnt_nxt = cnt_r;
        mem_en_nxt = mem_en_r;
        base_nxt = base_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        dtack_n_nxt = dtack_n_r;
        ip_nxt = ip_r;
        ipdo_nxt = ipdo_r;
        ipoe_nxt = ipoe_r;
        if (cnt_r != '1) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        unique case (state_r)
            S_IDLE: begin
                cnt_nxt = '0;
                if (ready_r && !vme.as_n && strobe && (a16_hit || a24_hit)) begin
                    state_nxt = S_HOLD;
                    slot_nxt = a24_hit ? a24_slot : vme.addr[9:8];
                    ip_nxt.addr = vme.addr[22:1];
                    ip_nxt.rw_n = vme.write_n;
                    ip_nxt.bs_n = vme.ds_n;
                    ipdo_nxt = vme.data;
                    dout_nxt = 16'h0000;
                    kind_nxt = K_NONE;
                    if (a24_hit) begin
                        kind_nxt = K_MEM;
                    end else if (vme.addr[7:6] == vmc_pkg::RGN_ID) begin
                        kind_nxt = K_ID;
                    end else if (vme.addr[7:6] != vmc_pkg::RGN_UPPER) begin
                        kind_nxt = K_IO;
                    end else if (vme.addr[9:8] == 2'h0) begin
                        kind_nxt = K_CAR;
                    end
                    if (a24_hit || vme.addr[7:6] != vmc_pkg::RGN_UPPER) begin
                        state_nxt = S_IP_SEL;
                    end
                    if (!a24_hit && vme.addr[9:6] == {2'h0, vmc_pkg::RGN_UPPER}) begin
                        dout_nxt = {8'h00, reg_rd(vme.addr[7:1], ready_r, mem_en_r, base_r)};
                        if (!vme.write_n && !vme.ds_n[0]) begin
                            if (vme.addr[7:1] == vmc_pkg::OFF_MEM_EN[7:1]) begin
                                mem_en_nxt = vme.data[3:0];
                            end
                            if (vme.addr[7:3] == vmc_pkg::OFF_BASE0[7:3]) begin
                                base_nxt[vme.addr[2:1]] = vme.data[7:0];
                            end
                        end
                    end
                end
            end
            S_IP_SEL: begin
                if (ip_tick) begin
                    state_nxt = S_IP_WAIT;
                    ipoe_nxt = !ip_r.rw_n;
                    ip_nxt.iosel_n[slot_r] = !(kind_r == K_IO);
                    ip_nxt.idsel_n[slot_r] = !(kind_r == K_ID);
                    ip_nxt.memsel_n[slot_r] = !(kind_r == K_MEM);
                end
            end
            S_IP_WAIT: begin
                // each idle tick is one wait state
                if (ip_tick && !ip_ack_n[slot_r]) begin
                    state_nxt = S_HOLD;
                    ip_nxt.iosel_n = 4'hF;
                    ip_nxt.idsel_n = 4'hF;
                    ip_nxt.memsel_n = 4'hF;
                    ipoe_nxt = 1'b0;
                    // even lane of ID is zero
                    dout_nxt = (kind_r == K_ID) ? {8'h00, ip_data_in[7:0]} : ip_data_in;
                end
            end
            S_HOLD: begin
                // acknowledge after base time and module cycle
                if (cnt_r >= vmc_pkg::CNT_W'(vmc_pkg::XFER_CYC - 1)) begin
                    state_nxt = S_DONE;
                    dtack_n_nxt = 1'b0;
                    doe_nxt = ip_r.rw_n;
                end
            end
            S_DONE: begin
                if (!strobe) begin
                    state_nxt = S_IDLE;
                    dtack_n_nxt = 1'b1;
                    doe_nxt = 1'b0;
                end
            end
        endcase
        dtack_oe_nxt = !dtack_n_nxt;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            kind_r <= K_NONE;
            slot_r <= 2'h0;
            cnt_r <= '0;
            cfg_r <= '0;
            ready_r <= 1'b0;
            mem_en_r <= vmc_pkg::MEM_EN_RST;
            base_r <= {4{vmc_pkg::BASE_RST}};
            dout_r <= 16'h0000;
            doe_r <= 1'b0;
            dtack_n_r <= 1'b1;
            dtack_oe_r <= 1'b0;
            ip_r <= '{iosel_n: 4'hF, idsel_n: 4'hF, memsel_n: 4'hF,
                      addr: '0, rw_n: 1'b1, bs_n: 2'h3};
            ipdo_r <= 16'h0000;
            ipoe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            slot_r <= slot_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            ready_r <= ready_nxt;
            mem_en_r <= mem_en_nxt;
            base_r <= base_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            dtack_n_r <= dtack_n_nxt;
            dtack_oe_r <= dtack_oe_nxt;
            ip_r <= ip_nxt;
            ipdo_r <= ipdo_nxt;
            ipoe_r <= ipoe_nxt;
        end
    end

    assign vme_data_out = dout_r;
    assign vme_data_oe = doe_r;
    assign vme_dtack_n = dtack_n_r;
    assign vme_dtack_oe = dtack_oe_r;
    assign ip_bus = ip_r;
    assign ip_data_out = ipdo_r;
    assign ip_data_oe = ipoe_r;

    a_no_ack_unready: assert property (@(posedge clock) disable iff (sys_rst)
        !ready_r |-> vme_dtack_n) else $error("acknowledge before ready");
    a_ready_delay: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(ready_r) |-> cfg_r == CFG_W'(CONFIG_CYC)) else $error("ready at wrong time");
    a_regs_reset: assert property (@(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> mem_en_r == 4'h0 && base_r == '0) else $error("controls not reset");
    a_car_ack_time: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(vme_dtack_n) && kind_r == K_CAR |-> cnt_r == vmc_pkg::CNT_W'(vmc_pkg::XFER_CYC))
        else $error("carrier ack time wrong");
    a_wait_stretch: assert property (@(posedge clock) disable iff (sys_rst)
        state_r == S_IP_WAIT && ip_ack_n[slot_r] |=> state_r == S_IP_WAIT && vme_dtack_n)
        else $error("wait state not honoured");
    a_ack_after_ip: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(vme_dtack_n) |-> &ip_bus.iosel_n && &ip_bus.idsel_n && &ip_bus.memsel_n
        && cnt_r >= vmc_pkg::CNT_W'(vmc_pkg::XFER_CYC)) else $error("ack during module cycle");
    a_mem_enable: assert property (@(posedge clock) disable iff (sys_rst)
        !ip_bus.memsel_n[slot_r] |-> mem_en_r[slot_r]) else $error("memory select disabled");
    a_id_even_zero: assert property (@(posedge clock) disable iff (sys_rst)
        vme_data_oe && kind_r == K_ID |-> vme_data_out[15:8] == 8'h00)
        else $error("id even lane not zero");
    a_one_select: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot0(~{ip_bus.iosel_n, ip_bus.idsel_n, ip_bus.memsel_n}))
        else $error("several selects active");
endmodule

// [vmc_ip_model.sv]
// Module-side partner for up to four slots with adjustable wait states
`timescale 1ns/100ps
module vmc_ip_model (
    input wire logic clock,
    input wire logic sys_rst,
    input vmc_pkg::vmc_ip_t ip_bus,
    input wire logic [15:0] ip_data_out,
    input wire logic ip_data_oe,
    input wire logic [3:0] wait_st,
    output logic [15:0] ip_data_in,
    output logic [3:0] ip_ack_n,
    output logic [15:0] last_wr
);
    logic tick;
    logic [3:0] sel;
    logic [3:0] wcnt_r;
    logic [3:0] wcnt_nxt;
    logic [15:0] prev_r;
    logic [15:0] last_wr_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic tick_nxt;
    assign sel = ~(ip_bus.iosel_n & ip_bus.idsel_n & ip_bus.memsel_n);
    // one wait state per module tick
    assign ip_ack_n = (wcnt_r == wait_st) ? ~sel : 4'hF;
    // Released lines show the inverse of the last value
    assign ip_data_in = (ip_ack_n != 4'hF) ? {ip_bus.addr[8:1], ~ip_bus.addr[8:1]} : ~prev_r;
    always_comb begin
        // Module clock phase, restarted with the carrier
        acc_nxt = acc_r + 8'(vmc_pkg::IP_ACC_STEP);
        tick_nxt = 1'b0;
        if (acc_nxt >= 8'(vmc_pkg::IP_ACC_MOD)) begin
            acc_nxt = acc_nxt - 8'(vmc_pkg::IP_ACC_MOD);
            tick_nxt = 1'b1;
        end
        wcnt_nxt = wcnt_r;
        last_wr_nxt = last_wr;
        if (sel == 4'h0) begin
            wcnt_nxt = 4'h0;
        end else if (tick && wcnt_r != wait_st) begin
            wcnt_nxt = wcnt_r + 4'h1;
        end
        if (tick && ip_ack_n != 4'hF && ip_data_oe) begin
            last_wr_nxt = ip_data_out;
        end
    end
    always_ff @(posedge clock) begin
        acc_r <= sys_rst ? 8'h00 : acc_nxt;
        tick <= sys_rst ? 1'b0 : tick_nxt;
        wcnt_r <= sys_rst ? 4'h0 : wcnt_nxt;
        last_wr <= sys_rst ? 16'h0000 : last_wr_nxt;
        prev_r <= ip_data_in;
    end
endmodule

// [vme_mezzanine_carrier_slave_test.sv]
// Self-checking bench for the carrier slave with its module-side partner
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module vme_mezzanine_carrier_slave_test;
    localparam int CFG = 20;
    localparam logic [5:0] BB = 6'h05;
    localparam logic [23:0] W = {8'h00, BB, 10'h000};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] board_base = BB;
    vmc_pkg::vmc_vme_t vme;
    vmc_pkg::vmc_ip_t ip_bus;
    logic [15:0] vme_data_out, ip_data_in, ip_data_out, last_wr, rd;
    logic vme_data_oe, vme_dtack_n, vme_dtack_oe, ip_data_oe;
    logic [3:0] ip_ack_n, wait_st, ipw;
    logic [1:0] doe;
    logic [11:0] seen;
    int errors = 0, n_checks = 0, cyc = 0, n, sel_cyc, sel_last;
    vmc_carrier_slave #(.CONFIG_CYC(CFG)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .board_base(board_base), .vme(vme), .vme_data_out(vme_data_out),
        .vme_data_oe(vme_data_oe), .vme_dtack_n(vme_dtack_n), .vme_dtack_oe(vme_dtack_oe),
        .ip_bus(ip_bus), .ip_data_in(ip_data_in), .ip_data_out(ip_data_out),
        .ip_data_oe(ip_data_oe), .ip_ack_n(ip_ack_n));
    vmc_ip_model u_ip (.clock(clock), .sys_rst(sys_rst), .ip_bus(ip_bus),
        .ip_data_out(ip_data_out), .ip_data_oe(ip_data_oe), .wait_st(wait_st),
        .ip_data_in(ip_data_in), .ip_ack_n(ip_ack_n), .last_wr(last_wr));
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
    endtask
    // One bus cycle; n is edges from take to acknowledge, 200 when none
    task automatic acc(input logic [5:0] am, input logic [23:0] a, input logic wr,
            input logic [15:0] wd);
        @(negedge clock);
        vme.am = am;
        vme.addr = a[23:1];
        vme.write_n = ~wr;
        vme.data = wd;
        vme.as_n = 1'b0;
        vme.ds_n = 2'h0;
        n = -1;
        rd = 16'h0000;
        seen = 12'h000;
        sel_cyc = 0;
        sel_last = 0;
        ipw = 4'h0;
        while (vme_dtack_n !== 1'b0 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
            if (~&{ip_bus.iosel_n, ip_bus.idsel_n, ip_bus.memsel_n}) begin
                sel_cyc++;
                sel_last = n;
                ipw = {ip_data_oe, ip_bus.rw_n, ip_bus.bs_n};
            end
            seen |= ~{ip_bus.memsel_n, ip_bus.idsel_n, ip_bus.iosel_n};
        end
        if (vme_dtack_n === 1'b0) rd = vme_data_out;
        doe = {vme_data_oe, vme_dtack_oe};
        @(negedge clock);
        vme.as_n = 1'b1;
        vme.ds_n = 2'h3;
        vme.addr = ~vme.addr;
        vme.data = ~vme.data;
        repeat (2) @(negedge clock);
    endtask
    task automatic wr16(input logic [23:0] a, input logic [15:0] d);
        acc(vmc_pkg::AM_A16_USR, a, 1'b1, d);
    endtask
    task automatic rd16(input logic [23:0] a);
        acc(vmc_pkg::AM_A16_SUP, a, 1'b0, 16'h0000);
    endtask
    task automatic t_ready();
        do_reset();
        rd16(W + 24'h0000C1);
        `CHK(n >= CFG + 55 && n <= CFG + 58, 1'b1)
        `CHK(rd, 16'h0001)
        `CHK(doe, 2'h3)
        rd16(W + 24'h0000C1);
        `CHK(n, 56)
    endtask
    task automatic t_regs();
        wr16(W + 24'h0000C7, 16'hFF0F);
        `CHK(doe, 2'h1)
        rd16(W + 24'h0000C7);
        `CHK(rd, 16'h000F)
        for (int s = 0; s < 4; s++) begin
            wr16(W + 24'h0000D1 + 24'(2 * s), {8'hFF, 8'h40 + 8'(s)});
            rd16(W + 24'h0000D1 + 24'(2 * s));
            `CHK(rd, {8'h00, 8'h40 + 8'(s)})
        end
        rd16(W + 24'h0000C9);
        `CHK(rd, 16'h0000)
        do_reset();
        repeat (CFG + 4) @(negedge clock);
        rd16(W + 24'h0000C7);
        `CHK(rd, 16'h0000)
        rd16(W + 24'h0000D7);
        `CHK(rd, 16'h0000)
    endtask
    task automatic t_decode();
        rd16(W ^ 24'h000400);
        `CHK(n, 200)
        `CHK(doe, 2'h0)
        acc(6'h09, W + 24'h0000C1, 1'b0, 16'h0000);
        `CHK(n, 200)
        rd16(W + 24'h0001C1);
        `CHK(rd, 16'h0000)
        `CHK(seen, 12'h000)
    endtask
    task automatic t_slots();
        logic [23:0] a;
        for (int s = 0; s < 4; s++) begin
            a = W + 24'(s * 256) + 24'h000010;
            rd16(a);
            `CHK(rd, {a[8:1], ~a[8:1]})
            `CHK(seen, 12'h001 << s)
            `CHK(ipw, 4'h4)
            a = W + 24'(s * 256) + 24'h000086;
            rd16(a);
            `CHK(rd, {8'h00, ~a[8:1]})
            `CHK(seen, 12'h010 << s)
        end
        wr16(W + 24'h000020, 16'hBEEF);
        `CHK(last_wr, 16'hBEEF)
        `CHK(ipw, 4'h8)
    endtask
    task automatic t_wait();
        wait_st = 4'h6;
        rd16(W + 24'h000302);
        `CHK(sel_cyc >= 105 && sel_cyc <= 112, 1'b1)
        `CHK(sel_last < n && n < 200, 1'b1)
        `CHK(rd, {8'h81, 8'h7E})
        wait_st = 4'h0;
    endtask
    task automatic t_mem();
        acc(vmc_pkg::AM_A24_SD, 24'h840010, 1'b0, 16'h0000);
        `CHK(n, 200)
        wr16(W + 24'h0000D5, 16'h0084);
        wr16(W + 24'h0000C7, 16'h0004);
        acc(vmc_pkg::AM_A24_UD, 24'h840010, 1'b0, 16'h0000);
        `CHK(seen, 12'h400)
        `CHK(rd, 16'h08F7)
        acc(vmc_pkg::AM_A24_UP, 24'h800010, 1'b0, 16'h0000);
        `CHK(n, 200)
        wr16(W + 24'h0000D5, 16'h0085);
        acc(vmc_pkg::AM_A24_SP, 24'h800010, 1'b0, 16'h0000);
        `CHK(seen, 12'h400)
        wr16(W + 24'h0000C7, 16'h0000);
        acc(vmc_pkg::AM_A24_UD, 24'h840010, 1'b0, 16'h0000);
        `CHK(n, 200)
    endtask
    initial begin
        vme = '0;
        vme.as_n = 1'b1;
        vme.ds_n = 2'h3;
        vme.write_n = 1'b1;
        wait_st = 4'h0;
        t_ready();
        t_regs();
        t_decode();
        t_slots();
        t_wait();
        t_mem();
        summarize();
    end
endmodule
